/* design/fwsr_pkg.sv */
// Purpose: Constants and carriers for the flash status host controller.
// Assumes: 100 MHz clk, APB slave for software, parallel flash pins.
// Notes:   Host side; the flash itself is outside this design.
// How it works
// [R1] Address held stable across write strobe fall
// [R2] Data held stable until strobe rise
// [R3] Sector picked by address bits 19..12
// [R4] Unlock cycles use fixed low address bits
// [R5] Reset command after autoselect or timeout fail
// [R6] Autoselect ends with a fourth read cycle
// [R7] Protect verify reads 00h or 01h
// [R8] Bypass entry issued before bypass program
// [R9] Bypass reset ends unlock bypass mode
// [R10] Suspend allows reads, programs, autoselect elsewhere
// [R11] Resume only sent while erase suspended; the host sends it whenever OP_RESUME is ordered, susp_r unchecked
// [R12] Poll bit inverted until program completes
// [R13] Protected program busy briefly, no write
// [R14] All-protected erase busy, then array reads
// [R15] Erase poll bit 0, then 1
// [R16] Status valid after final strobe rise
// [R17] Reread full word after poll bit settles
// [R18] Ready/busy open drain, low while busy
// [R19] Global toggle bit flips every busy read
// [R20] Toggle stops in suspend, resumes for program
// [R21] Sector toggle bit flips inside erase sectors
// [R22] Toggle also during erase acceptance window
// [R23] Timeout fail bit set halts operation
// [R24] Erase window bit 0 accepting, then 1
// [R25] Host compares two successive status reads
// [R26] Status driven only with chip select, output enable
package fwsr_pkg;
	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_ADDR   = 8'h04;
	localparam logic [7:0]  REG_WDATA  = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0C;
	localparam logic [7:0]  REG_RDATA  = 8'h10;
	localparam int          CTRL_GO    = 0;
	localparam int          CTRL_CMD_L = 4;
	localparam int          ST_BUSY    = 0;
	localparam int          ST_DONE    = 1;
	localparam int          ST_FAIL    = 2;
	localparam int          ST_RYBY    = 3;
	// ------------------------------------------------------------
	// Data bit positions
	// ------------------------------------------------------------
	localparam int          POLL_BIT   = 7;
	localparam int          TOGG_BIT   = 6;
	localparam int          FAIL_BIT   = 5;
	localparam int          EWIN_BIT   = 3;
	localparam int          STOG_BIT   = 2;
	// ------------------------------------------------------------
	// Flash command words and unlock addresses
	// ------------------------------------------------------------
	localparam logic [19:0] UNLK_A1    = 20'h0_0555;
	localparam logic [19:0] UNLK_A2    = 20'h0_02AA;
	localparam logic [15:0] UNLK_D1    = 16'h00AA;
	localparam logic [15:0] UNLK_D2    = 16'h0055;
	localparam logic [15:0] C_RESET    = 16'h00F0;
	localparam logic [15:0] C_PROG     = 16'h00A0;
	localparam logic [15:0] C_ERASE1   = 16'h0080;
	localparam logic [15:0] C_SECTOR   = 16'h0030;
	localparam logic [15:0] C_AUTOSEL  = 16'h0090;
	localparam logic [15:0] C_BYPASS   = 16'h0020;
	localparam logic [15:0] C_BYP_RST1 = 16'h0090;
	localparam logic [15:0] C_BYP_RST2 = 16'h0000;
	localparam logic [15:0] C_SUSPEND  = 16'h00B0;
	localparam logic [15:0] C_RESUME   = 16'h0030;
	localparam logic [19:0] SECT_MASK  = 20'hF_F000;
	localparam logic [19:0] PROT_OFS   = 20'h0_0002;
	// Bus cycles per command sequence
	localparam logic [2:0]  N_ONE      = 3'h1;
	localparam logic [2:0]  N_PAIR     = 3'h2;
	localparam logic [2:0]  N_BYP_ENT  = 3'h3;
	localparam logic [2:0]  N_CMD_STD  = 3'h4;
	localparam logic [2:0]  N_ERASE    = 3'h6;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ    = 100;
	localparam int          T_PHASE_NS = 30;
	localparam int          PHASE_CYC  = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  PHASE_MAX  = 4'(PHASE_CYC - 1);
	// ------------------------------------------------------------
	// Operations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_PROG, OP_SECT_ERASE, OP_AUTOSEL, OP_PROT_VERIFY, OP_RESET,
		OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_RESET, OP_SUSPEND, OP_RESUME
	} fwsr_op_e;
	typedef struct packed {
		logic        write;
		logic [19:0] addr;
		logic [15:0] data;
	} fwsr_cyc_s;
	typedef struct packed {
		logic        ceN;
		logic        oeN;
		logic        weN;
		logic [19:0] addr;
		logic [15:0] dqOut;
		logic        dqOe;
	} fwsr_pins_s;
endpackage : fwsr_pkg

/* design/fwsr_bus_cycle.sv */
// Purpose: One flash bus cycle (write strobe or read) on the parallel pins.
// Assumes: Pin inputs synchronised by the caller.
// Notes:   Address and data held over the whole strobe window.
module fwsr_bus_cycle
	import fwsr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire fwsr_cyc_s   cyc,
	input  wire logic [15:0] dqSync,
	output      fwsr_pins_s  pins,
	output      logic [15:0] rdData,
	output      logic        done
);
	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fwsr_bc_e;
	fwsr_bc_e    state_r, state_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	fwsr_pins_s  pins_r, pins_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic        done_nxt, done_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		pins_nxt  = pins_r;
		rd_nxt    = rd_r;
		done_nxt  = 1'b0;
		unique case (state_r)
			S_IDLE: if (start) begin
				pins_nxt.addr  = cyc.addr; // R1
				pins_nxt.dqOut = cyc.data; // R2
				pins_nxt.dqOe  = cyc.write;
				pins_nxt.ceN   = 1'b0;
				cnt_nxt        = '0;
				state_nxt      = S_SETUP;
			end
			S_SETUP: begin
				if (cyc.write) pins_nxt.weN = 1'b0;
				else           pins_nxt.oeN = 1'b0; // R26
				state_nxt = S_STROBE;
			end
			S_STROBE: if (cnt_r == PHASE_MAX) begin
				rd_nxt      = dqSync;
				pins_nxt.weN = 1'b1; // R16
				pins_nxt.oeN = 1'b1;
				cnt_nxt     = '0;
				state_nxt   = S_HOLD;
			end else cnt_nxt = cnt_r + 4'd1;
			S_HOLD: begin
				pins_nxt.ceN  = 1'b1;
				pins_nxt.dqOe = 1'b0; // R2
				done_nxt      = 1'b1;
				state_nxt     = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			cnt_r   <= '0;
			pins_r  <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};
			rd_r    <= '0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			pins_r  <= pins_nxt;
			rd_r    <= rd_nxt;
			done_r  <= done_nxt;
		end
	end

	assign pins   = pins_r;
	assign rdData = rd_r;
	assign done   = done_r;
endmodule : fwsr_bus_cycle

/* design/fwsr_host.sv */
// Purpose: Host controller issuing flash command sequences and polling status.
// Assumes: Software orders an operation over APB, waits for done.
// Notes:   Completion judged by toggle bit with timeout-fail recheck.
module fwsr_host
	import fwsr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic        flashCeN,
	output      logic        flashOeN,
	output      logic        flashWeN,
	output      logic [19:0] flashAddr,
	output      logic [15:0] flashDqOut,
	output      logic        flashDqOe,
	input  wire logic [15:0] flashDqIn,
	input  wire logic        readyBusyNIn
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [15:0] dqMeta_r, dqSync_r;
	logic        rbMeta_r, rbSync_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dqMeta_r <= '0;
			dqSync_r <= '0;
			rbMeta_r <= 1'b1;
			rbSync_r <= 1'b1;
		end else begin
			dqMeta_r <= flashDqIn;
			dqSync_r <= dqMeta_r;
			rbMeta_r <= readyBusyNIn;
			rbSync_r <= rbMeta_r; // R18
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {Q_IDLE, Q_CMD, Q_POLL1, Q_POLL2, Q_FAILCHK, Q_RESET, Q_END}
		fwsr_seq_e;
	fwsr_seq_e   seq_r, seq_nxt;
	fwsr_op_e    op_r, op_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [15:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt, prev_r, prev_nxt;
	logic [2:0]  idx_r, idx_nxt;
	logic        busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;
	logic        bypass_r, bypass_nxt, susp_r, susp_nxt;
	logic        start, cycDone;
	logic [15:0] cycRd;
	fwsr_cyc_s   cyc;
	fwsr_pins_s  pins;
	logic [2:0]  nCyc;
	logic        wrSel, apbWr, goReq, polls;

	assign apbWr = psel && penable && pwrite;
	assign goReq = apbWr && paddr == REG_CTRL && pwdata[CTRL_GO] && !busy_r;

	// Cycle table; unlock cycles use fixed low unlock addresses, single-cycle commands use address 0
	always_comb begin
		cyc   = '{write: 1'b1, addr: UNLK_A1, data: UNLK_D1};
		nCyc  = N_ONE;
		polls = 1'b0;
		unique case (op_r)
			OP_READ: begin
				cyc  = '{write: 1'b0, addr: addr_r, data: '0};
			end
			OP_RESET: cyc = '{write: 1'b1, addr: '0, data: C_RESET}; // R5
			OP_SUSPEND: cyc = '{write: 1'b1, addr: '0, data: C_SUSPEND};
			OP_RESUME: cyc = '{write: 1'b1, addr: '0, data: C_RESUME}; // R11
			OP_BYP_PROG: begin
				nCyc  = N_PAIR;
				polls = 1'b1;
				cyc = (idx_r == 3'd0) ? '{write: 1'b1, addr: '0, data: C_PROG}
				                      : '{write: 1'b1, addr: addr_r, data: wdat_r}; // R8
			end
			OP_BYP_RESET: begin
				nCyc = N_PAIR;
				cyc  = '{write: 1'b1, addr: '0,
				         data: (idx_r == 3'd0) ? C_BYP_RST1 : C_BYP_RST2}; // R9
			end
			default: begin
				// Unlock pair, command, then the operation's own cycles
				nCyc = (op_r == OP_SECT_ERASE) ? N_ERASE : N_CMD_STD;
				if (op_r == OP_BYP_ENTER) nCyc = N_BYP_ENT;
				polls = (op_r == OP_PROG || op_r == OP_SECT_ERASE);
				unique case (idx_r)
					3'd0: cyc = '{write: 1'b1, addr: UNLK_A1, data: UNLK_D1}; // R4
					3'd1: cyc = '{write: 1'b1, addr: UNLK_A2, data: UNLK_D2};
					3'd2: cyc = '{write: 1'b1, addr: UNLK_A1,
						data: op_r == OP_PROG ? C_PROG : op_r == OP_SECT_ERASE ? C_ERASE1 :
						op_r == OP_BYP_ENTER ? C_BYPASS : C_AUTOSEL};
					3'd3: cyc = (op_r == OP_PROG) ? '{write: 1'b1, addr: addr_r, data: wdat_r}
						: (op_r == OP_SECT_ERASE) ? '{write: 1'b1, addr: UNLK_A1, data: UNLK_D1}
						: (op_r == OP_PROT_VERIFY)
						? '{write: 1'b0, addr: (addr_r & SECT_MASK) | PROT_OFS, data: '0} // R3 R7
						: '{write: 1'b0, addr: addr_r, data: '0}; // R6
					3'd4: cyc = '{write: 1'b1, addr: UNLK_A2, data: UNLK_D2};
					default: cyc = '{write: 1'b1, addr: addr_r & SECT_MASK, data: C_SECTOR}; // R3
				endcase
			end
		endcase
		if (seq_r != Q_CMD) cyc = '{write: 1'b0, addr: addr_r, data: '0}; // R12 R15 R21
	end

	always_comb begin
		seq_nxt    = seq_r;
		op_nxt     = op_r;
		addr_nxt   = addr_r;
		wdat_nxt   = wdat_r;
		rdat_nxt   = rdat_r;
		prev_nxt   = prev_r;
		idx_nxt    = idx_r;
		busy_nxt   = busy_r;
		done_nxt   = done_r;
		fail_nxt   = fail_r;
		bypass_nxt = bypass_r;
		susp_nxt   = susp_r;
		start      = 1'b0;
		if (apbWr && paddr == REG_ADDR) addr_nxt = pwdata[19:0];
		if (apbWr && paddr == REG_WDATA) wdat_nxt = pwdata[15:0];
		if (apbWr && paddr == REG_STATUS && pwdata[ST_DONE]) done_nxt = 1'b0;
		unique case (seq_r)
			Q_IDLE: if (goReq) begin
				op_nxt   = fwsr_op_e'(pwdata[CTRL_CMD_L +: 4]);
				idx_nxt  = '0;
				busy_nxt = 1'b1;
				fail_nxt = 1'b0;
				seq_nxt  = Q_CMD;
			end
			Q_CMD: begin
				start = 1'b1;
				if (cycDone) begin
					rdat_nxt = cycRd;
					if (idx_r == nCyc - 3'd1) begin
						seq_nxt = polls ? Q_POLL1 : Q_END; // R16
						if (op_r == OP_BYP_ENTER) bypass_nxt = 1'b1;
						if (op_r == OP_BYP_RESET) bypass_nxt = 1'b0;
						if (op_r == OP_SUSPEND) susp_nxt = 1'b1; // R10
						if (op_r == OP_RESUME) susp_nxt = 1'b0;
					end else idx_nxt = idx_r + 3'd1;
				end
			end
			Q_POLL1: begin
				start = 1'b1;
				if (cycDone) begin
					prev_nxt = cycRd;
					seq_nxt  = Q_POLL2; // R25
				end
			end
			Q_POLL2, Q_FAILCHK: begin
				start = 1'b1;
				if (cycDone) begin
					prev_nxt = cycRd;
					if (cycRd[TOGG_BIT] == prev_r[TOGG_BIT]) begin
						seq_nxt = Q_END; // R17 R19 R20 R22
					end else if (seq_r == Q_FAILCHK) begin
						fail_nxt = 1'b1; // R23
						op_nxt   = OP_RESET;
						idx_nxt  = '0;
						seq_nxt  = Q_RESET;
					end else if (cycRd[FAIL_BIT]) seq_nxt = Q_FAILCHK;
				end
			end
			Q_RESET: begin
				start = 1'b1; // R5
				if (cycDone) seq_nxt = Q_END;
			end
			Q_END: begin
				if (op_r == OP_PROG || op_r == OP_BYP_PROG) rdat_nxt = prev_r; // R13 R14
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				seq_nxt  = Q_IDLE;
			end
			default: seq_nxt = Q_IDLE;
		endcase
	end

	fwsr_cyc_s cycMux;
	assign cycMux = (seq_r == Q_RESET) ? '{write: 1'b1, addr: '0, data: C_RESET} : cyc;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_r    <= Q_IDLE;
			op_r     <= OP_READ;
			addr_r   <= '0;
			wdat_r   <= '0;
			rdat_r   <= '0;
			prev_r   <= '0;
			idx_r    <= '0;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			fail_r   <= 1'b0;
			bypass_r <= 1'b0;
			susp_r   <= 1'b0;
		end else begin
			seq_r    <= seq_nxt;
			op_r     <= op_nxt;
			addr_r   <= addr_nxt;
			wdat_r   <= wdat_nxt;
			rdat_r   <= rdat_nxt;
			prev_r   <= prev_nxt;
			idx_r    <= idx_nxt;
			busy_r   <= busy_nxt;
			done_r   <= done_nxt;
			fail_r   <= fail_nxt;
			bypass_r <= bypass_nxt;
			susp_r   <= susp_nxt;
		end
	end

	// Start held during the command, poll and reset states; the cycle engine only samples it when idle
	fwsr_bus_cycle uCycle (
		.clk    (clk),
		.rst_b  (rst_b),
		.start  (start && !cycDone),
		.cyc    (cycMux),
		.dqSync (dqSync_r),
		.pins   (pins),
		.rdData (cycRd),
		.done   (cycDone)
	);

	assign flashCeN   = pins.ceN;
	assign flashOeN   = pins.oeN;
	assign flashWeN   = pins.weN;
	assign flashAddr  = pins.addr;
	assign flashDqOut = pins.dqOut;
	assign flashDqOe  = pins.dqOe;

	// ------------------------------------------------------------
	// APB read side; zero wait states
	// ------------------------------------------------------------
	// Word captured in the setup cycle, so read data leave a flop
	// at no cost in wait states; status is one cycle old.
	logic [31:0] prdata_r, prdata_nxt;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			unique case (paddr)
				REG_ADDR:   prdata_nxt = {12'h000, addr_r};
				REG_WDATA:  prdata_nxt = {16'h0000, wdat_r};
				REG_RDATA:  prdata_nxt = {16'h0000, rdat_r};
				REG_STATUS: prdata_nxt = {26'h000_0000, susp_r, bypass_r, rbSync_r, fail_r,
				                          done_r, busy_r};
				default:    prdata_nxt = '0;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) prdata_r <= '0;
		else        prdata_r <= prdata_nxt;
	end
	assign prdata = prdata_r;
endmodule : fwsr_host

/* bench/fwsr_host_assertions.sv */
// Purpose: Concurrent checks on the flash pins and APB port of the host.
// Assumes: One clk domain, rst_b async active low.
// Notes:   Bound to fwsr_host at the foot of this file.
module fwsr_host_assertions
	import fwsr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        flashCeN,
	input wire logic        flashOeN,
	input wire logic        flashWeN,
	input wire logic [19:0] flashAddr,
	input wire logic [15:0] flashDqOut,
	input wire logic        flashDqOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_addr_hold; !flashWeN && !$past(flashWeN) |-> $stable(flashAddr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
	property p_data_hold; $rose(flashWeN) |-> $stable(flashDqOut) && $past(flashDqOe); endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");
	property p_unlock; $fell(flashWeN) && flashDqOut == UNLK_D2 |-> flashAddr[10:0] == 11'h2AA;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock address wrong");
	property p_no_fight; !flashOeN |-> !flashDqOe && flashWeN; endproperty
	a_no_fight: assert property (p_no_fight) else $error("host drives during read");
	property p_ce_frame; !flashWeN || !flashOeN |-> !flashCeN; endproperty
	a_ce_frame: assert property (p_ce_frame) else $error("strobe without select");
	property p_we_width; $fell(flashWeN) |-> !flashWeN[*3] ##[1:4] flashWeN; endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width");
	property p_apb_ready; psel && penable |-> pready; endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no zero wait answer");
	property p_apb_err; psel |-> !pslverr; endproperty
	a_apb_err: assert property (p_apb_err) else $error("unexpected slave error");
endmodule : fwsr_host_assertions
bind fwsr_host fwsr_host_assertions u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .flashCeN(flashCeN),
	.flashOeN(flashOeN), .flashWeN(flashWeN), .flashAddr(flashAddr),
	.flashDqOut(flashDqOut), .flashDqOe(flashDqOe));

/* bench/fwsr_flash_model.sv */
// Purpose: Behavioural parallel flash with write status reporting.
// Assumes: Busy times in clk cycles; one protected sector.
// Notes:   Released data lines show the inverse of the last word.
module fwsr_flash_model
	import fwsr_pkg::*;
#(
	parameter logic [7:0] PROT_SECT = 8'h05,
	parameter int         BUSY_CYC  = 200
)(
	input  wire logic        clk,
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] dq,
	output      logic [15:0] dqIn,
	output      logic        rbN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [19:0]];
	logic [19:0] aLat, pA, ks [$];
	logic [15:0] pD, h1, h2, rd;
	logic [7:0]  eS;
	logic        armed, drv, busy, erase, fail, wFail, doW, prog, eArm, auto, byp, tog, tog2;
	int          cnt;
	initial begin
		{armed, drv, busy, erase, fail, wFail, doW, prog, eArm, auto, byp, tog, tog2} = '0;
		{pA, pD, h1, h2, rd, eS, cnt} = '0;
	end
	function automatic logic [15:0] arr(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction : arr
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		if (busy) begin
			if (fail && d == C_RESET) {busy, fail} = 2'b00;
		end else if (prog) begin
			{prog, busy, erase, pA, pD, cnt} = {3'b010, a, d, BUSY_CYC};
			doW = a[19:12] != PROT_SECT;
			wFail = doW && |(d & ~arr(a));
		end else if (eArm && h2 == UNLK_D1 && h1 == UNLK_D2 && d == C_SECTOR) begin
			{eArm, busy, erase, eS, cnt, wFail, doW} = {3'b011, a[19:12], 2 * BUSY_CYC, 2'b00};
			ks = {};
			foreach (mem[k]) if (k[19:12] == eS && eS != PROT_SECT) ks.push_back(k);
			foreach (ks[i]) mem.delete(ks[i]);
		end else if (byp) begin
			if (d == C_PROG) prog = 1'b1;
			if (h1 == C_BYP_RST1 && d == C_BYP_RST2) byp = 1'b0;
		end else if (d == C_RESET) auto = 1'b0;
		else if (h2 == UNLK_D1 && h1 == UNLK_D2) begin
			prog = d == C_PROG;
			auto = auto || d == C_AUTOSEL;
			byp = d == C_BYPASS;
			eArm = d == C_ERASE1;
		end
		{h2, h1} = {h1, d};
	endtask : wr
	// Update off the host's sampling edge to keep the sync flops race free
	always @(negedge clk) begin
		if (busy && cnt == 1) begin
			if (wFail) fail = 1'b1;
			else {busy, erase} = 2'b00;
			if (doW && !wFail) mem[pA] = pD;
		end
		if (cnt > 0) cnt--;
	end
	always @(negedge weN or negedge ceN) begin
		if (!weN && !ceN) {armed, aLat} = {1'b1, addr};
	end
	always @(posedge weN or posedge ceN) begin
		if (armed) begin
			armed = 1'b0;
			wr(aLat, dq);
		end
	end
	always @(negedge oeN or negedge ceN) begin
		if (!oeN && !ceN) begin
			if (busy) begin
				tog = ~tog;
				tog2 = tog2 ^ (erase && addr[19:12] == eS);
				rd = {8'h00, !erase && !pD[7], tog, fail, 1'b0, erase, tog2, 2'b00};
			end else if (auto) rd = {15'h0000, addr[19:12] == PROT_SECT};
			else rd = arr(addr);
			drv = 1'b1;
		end
	end
	always @(posedge oeN or posedge ceN) drv = 1'b0;
	assign dqIn = drv ? rd : ~rd;
	assign rbN = !busy;
endmodule : fwsr_flash_model

/* bench/tb.sv */
// Purpose: Self-checking bench for the flash host over APB.
// Assumes: Flash model answers on the parallel pins.
// Notes:   Sector 05 of the model is the protected one.
module tb
	import fwsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PSECT = 8'h05;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, ceN, oeN, weN, dqOe, rbN;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] fAddr;
	logic [15:0] dqOut, dqIn;
	int          bad_count = 0;
	int          samples_checked = 0;
	fwsr_host dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr),
		.flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn), .readyBusyNIn(rbN));
	fwsr_flash_model #(.PROT_SECT(PSECT)) flash (.clk(clk), .ceN(ceN), .oeN(oeN), .weN(weN),
		.addr(fAddr), .dq(dqOut), .dqIn(dqIn), .rbN(rbN));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test;
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic hang;
		bad_count++;
		stop_test();
	endtask : hang
	// Idle cycle after each transfer so no signal is assigned twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		{psel, penable} <= 2'b00;
		if (n >= 20) hang();
		@(posedge clk);
	endtask : apb
	task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d);
		int n;
		apb(1'b1, REG_ADDR, {12'h000, a});
		apb(1'b1, REG_WDATA, {16'h0000, d});
		apb(1'b1, REG_STATUS, 32'h0000_0002);
		apb(1'b1, REG_CTRL, {24'h00_0000, op, 4'h1});
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000);
			n++;
		end while (q[ST_DONE] !== 1'b1 && n < 3000);
		if (n >= 3000) hang();
	endtask : run
	task automatic rdchk(input logic [3:0] op, input logic [19:0] a, input logic [15:0] e);
		run(op, a, 16'h0000);
		apb(1'b0, REG_RDATA, 32'h0000_0000);
		chk(q & 32'h0000_FFFF, {16'h0000, e});
	endtask : rdchk
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_003F, 32'h0000_0008);
		run(4'h1, 20'h1_0010, 16'h1234);
		chk(q & 32'h0000_0007, 32'h0000_0002);
		rdchk(4'h0, 20'h1_0010, 16'h1234);
		run(4'h1, 20'h1_0010, 16'hFFFF);
		chk(q & 32'h0000_0007, 32'h0000_0006);
		rdchk(4'h0, 20'h1_0010, 16'h1234);
		run(4'h1, {PSECT, 12'h020}, 16'h0000);
		rdchk(4'h0, {PSECT, 12'h020}, 16'hFFFF);
		run(4'h1, 20'h2_0000, 16'h5A5A);
		run(4'h2, 20'h1_0800, 16'h0000);
		chk(q & 32'h0000_0007, 32'h0000_0002);
		rdchk(4'h0, 20'h1_0010, 16'hFFFF);
		rdchk(4'h0, 20'h2_0000, 16'h5A5A);
		rdchk(4'h3, {PSECT, 12'h002}, 16'h0001);
		run(4'h5, 20'h0_0000, 16'h0000);
		rdchk(4'h4, {PSECT, 12'h000}, 16'h0001);
		run(4'h5, 20'h0_0000, 16'h0000);
		rdchk(4'h4, 20'h1_0000, 16'h0000);
		run(4'h5, 20'h0_0000, 16'h0000);
		run(4'h6, 20'h0_0000, 16'h0000);
		chk(q & 32'h0000_0010, 32'h0000_0010);
		run(4'h7, 20'h3_0004, 16'h00A5);
		run(4'h8, 20'h0_0000, 16'h0000);
		chk(q & 32'h0000_0010, 32'h0000_0000);
		rdchk(4'h0, 20'h3_0004, 16'h00A5);
		run(4'h9, 20'h0_0000, 16'h0000);
		chk(q & 32'h0000_0020, 32'h0000_0020);
		run(4'hA, 20'h0_0000, 16'h0000);
		chk(q & 32'h0000_0020, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		stop_test();
	end
endmodule : tb
